// [frpc_top.sv]
// Purpose: hardware reset, software reset and power-on state of the flash device
// Assumes: rst_n is the internal power-on reset; pins arrive asynchronously
// Notes: recovery waits after a reset are kept by the host, not measured here
// Summary of operation
// - after hardware reset: standby, write latch and busy flags at power-on defaults
// - after hardware reset the second configuration register volatile bits reload defaults
// - after hardware reset the first chip select low starts the fastboot read
// - reset during program or erase aborts that operation; data may be lost
// - during hardware reset the data lines float and activity drops to minimum
// - at power-up the memory is in standby with the write latch cleared
// - while power-on reset is active, logic is held and commands ignored
// - software reset acts only when no other command comes between arm and execute; idle cycles between them keep the arm
`timescale 1ns/1ps
`include "frpc_defines.svh"
module frpc_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reset_pin_n,
  input wire logic chip_select_n,
  input wire frpc_pkg::frpc_cmd_t cmd,
  input wire frpc_pkg::frpc_core_t core_ev,
  input wire logic data_drive_req,
  input wire logic cfg2_wr_en,
  input wire logic [`FRPC_CFG2_WIDTH-1:0] cfg2_wr_data,
  output frpc_pkg::frpc_status_t status,
  output logic [`FRPC_CFG2_WIDTH-1:0] second_config_register,
  output logic octal_data_lines_oe,
  output logic core_hold,
  output logic low_power,
  output logic cmd_accept,
  output logic abort_op,
  output logic fastboot_start,
  output logic soft_reset_done
);
  import frpc_pkg::*;

  logic [1:0] pins_sync;
  logic reset_pin_s;
  logic select_n_s;
  logic select_n_d_r;
  logic [`FRPC_FILT_CNT_W-1:0] filt_cnt_r;
  logic [`FRPC_FILT_CNT_W-1:0] filt_cnt_nxt;
  frpc_state_t state_r;
  frpc_state_t state_nxt;
  logic arm_r;
  logic arm_nxt;
  logic fastboot_pend_r;
  logic op_running_r;
  logic hw_reset_now;
  logic soft_reset_now;
  logic any_reset;
  logic select_fall;
  logic in_hold;
  logic leave_hold;

  frpc_sync #(
    .WIDTH(2),
    .INIT(2'b11)
  ) u_pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in({reset_pin_n, chip_select_n}),
    .sync_out(pins_sync)
  );

  assign reset_pin_s = pins_sync[1];
  assign select_n_s = pins_sync[0];

  // a short glitch on the reset pin is not a guaranteed reset; filter it out
  assign filt_cnt_nxt = reset_pin_s ? '0 :
                        (filt_cnt_r == `FRPC_FILT_CNT_W'(`FRPC_RESET_FILTER_CYC)) ? filt_cnt_r :
                        filt_cnt_r + `FRPC_FILT_CNT_W'(1);
  assign hw_reset_now = !reset_pin_s &&
                        (filt_cnt_r == `FRPC_FILT_CNT_W'(`FRPC_RESET_FILTER_CYC));

  assign in_hold = (state_r == FRPC_ST_HOLD);
  assign select_fall = select_n_d_r && !select_n_s && !in_hold;

  // arming is kept only across the single command that follows it
  assign soft_reset_now = cmd.valid && cmd.reset_exec_cmd && arm_r && !in_hold;
  assign arm_nxt = (!cmd.valid || in_hold) ? (arm_r && !in_hold) :
                   (cmd.reset_arm_cmd && !cmd.reset_exec_cmd);
  assign any_reset = hw_reset_now || soft_reset_now;
  assign leave_hold = in_hold && reset_pin_s;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FRPC_ST_HOLD: begin
        if (reset_pin_s) begin
          state_nxt = FRPC_ST_STANDBY;
        end
      end
      FRPC_ST_STANDBY: begin
        if (hw_reset_now) begin
          state_nxt = FRPC_ST_HOLD;
        end else if (soft_reset_now) begin
          state_nxt = FRPC_ST_STANDBY;
        end else if (core_ev.op_start) begin
          state_nxt = FRPC_ST_OPER;
        end
      end
      FRPC_ST_OPER: begin
        if (hw_reset_now) begin
          state_nxt = FRPC_ST_HOLD;
        end else if (soft_reset_now || core_ev.op_done) begin
          state_nxt = FRPC_ST_STANDBY;
        end
      end
      default: begin
        state_nxt = FRPC_ST_HOLD;
      end
    endcase
  end

  // power-on reset: held in reset, standby defaults loaded, no commands
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= FRPC_ST_HOLD;
      filt_cnt_r <= '0;
      select_n_d_r <= 1'b1;
      arm_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      filt_cnt_r <= filt_cnt_nxt;
      select_n_d_r <= select_n_s;
      arm_r <= arm_nxt;
    end
  end

  // flags; a reset outranks any core event in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status.write_latch_flag <= `FRPC_WRITE_LATCH_DEFAULT;
      status.write_busy_flag <= `FRPC_WRITE_BUSY_DEFAULT;
      status.standby <= 1'b0;
    end else begin
      if (any_reset || in_hold) begin
        status.write_latch_flag <= `FRPC_WRITE_LATCH_DEFAULT;
      end else if (core_ev.write_latch_set) begin
        status.write_latch_flag <= 1'b1;
      end else if (core_ev.write_latch_clear) begin
        status.write_latch_flag <= 1'b0;
      end
      if (any_reset || in_hold) begin
        status.write_busy_flag <= `FRPC_WRITE_BUSY_DEFAULT;
      end else if (core_ev.op_start) begin
        status.write_busy_flag <= 1'b1;
      end else if (core_ev.op_done) begin
        status.write_busy_flag <= 1'b0;
      end
      status.standby <= (state_nxt == FRPC_ST_STANDBY);
    end
  end

  // second configuration register, volatile part
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      second_config_register <= `FRPC_CFG2_DEFAULT;
    end else if (any_reset || in_hold) begin
      second_config_register <= `FRPC_CFG2_DEFAULT;
    end else if (cfg2_wr_en) begin
      second_config_register <= cfg2_wr_data;
    end
  end

  // operation tracking and abort
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_running_r <= 1'b0;
      abort_op <= 1'b0;
    end else begin
      abort_op <= any_reset && (op_running_r || core_ev.op_start);
      if (any_reset || in_hold) begin
        op_running_r <= 1'b0;
      end else if (core_ev.op_start && core_ev.op_is_prog_erase) begin
        op_running_r <= 1'b1;
      end else if (core_ev.op_done) begin
        op_running_r <= 1'b0;
      end
    end
  end

  // fastboot is armed by every reset and fired by the first select after it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fastboot_pend_r <= 1'b1;
      fastboot_start <= 1'b0;
    end else begin
      fastboot_start <= select_fall && fastboot_pend_r && !any_reset;
      if (any_reset || in_hold) begin
        fastboot_pend_r <= 1'b1;
      end else if (select_fall) begin
        fastboot_pend_r <= 1'b0;
      end
    end
  end

  // pin-facing and core-facing controls
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      octal_data_lines_oe <= 1'b0;
      core_hold <= 1'b1;
      low_power <= 1'b1;
      cmd_accept <= 1'b0;
      soft_reset_done <= 1'b0;
    end else begin
      // lines float and current drops for the whole hold
      octal_data_lines_oe <= data_drive_req && !hw_reset_now &&
                             (state_nxt != FRPC_ST_HOLD);
      low_power <= (state_nxt == FRPC_ST_HOLD);
      core_hold <= (state_nxt == FRPC_ST_HOLD) || soft_reset_now;
      cmd_accept <= (state_nxt != FRPC_ST_HOLD) && !leave_hold;
      soft_reset_done <= soft_reset_now;
    end
  end

endmodule

// [frpc_defines.svh]
// Purpose: constants for the flash reset and power-on control block
// Assumes: core_clk at 40 MHz
// Notes: definitions only
`ifndef FRPC_DEFINES_SVH
`define FRPC_DEFINES_SVH

`define FRPC_CORE_CLK_MHZ 40
`define FRPC_CFG2_WIDTH 8
// power-on default of the volatile bits of the second configuration register
`define FRPC_CFG2_DEFAULT 8'h00
`define FRPC_WRITE_LATCH_DEFAULT 1'b0
`define FRPC_WRITE_BUSY_DEFAULT 1'b0
// the shortest low on the reset pin that is still taken as a reset, in ns
`define FRPC_RESET_FILTER_NS 100
`define FRPC_RESET_FILTER_CYC ((`FRPC_RESET_FILTER_NS * `FRPC_CORE_CLK_MHZ + 999) / 1000)
`define FRPC_FILT_CNT_W 4

`endif

// [frpc_pkg.sv]
// Purpose: shared types of the flash reset and power-on control block
// Assumes: used together with frpc_defines.svh
// Notes: carriers for command decode and status flags
package frpc_pkg;

  typedef enum logic [2:0] {
    FRPC_ST_HOLD = 3'b001,
    FRPC_ST_STANDBY = 3'b010,
    FRPC_ST_OPER = 3'b100
  } frpc_state_t;

  typedef struct packed {
    logic valid;
    logic reset_arm_cmd;
    logic reset_exec_cmd;
  } frpc_cmd_t;

  typedef struct packed {
    logic write_latch_set;
    logic write_latch_clear;
    logic op_start;
    logic op_done;
    logic op_is_prog_erase;
  } frpc_core_t;

  typedef struct packed {
    logic standby;
    logic write_latch_flag;
    logic write_busy_flag;
  } frpc_status_t;

endpackage

// [frpc_sync.sv]
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to core_clk
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps
module frpc_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_r <= INIT;
      sync_out <= INIT;
    end else begin
      stage1_r <= async_in;
      sync_out <= stage1_r;
    end
  end

endmodule

// [frpc_top_props.sv]
// Purpose: port checks for frpc_top
// Assumes: one clock domain, rst_n as the power-on reset
// Notes: pin reset must reach hold within eight low samples
`timescale 1ns/1ps
`include "frpc_defines.svh"
module frpc_top_props (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reset_pin_n,
  input wire logic chip_select_n,
  input wire frpc_pkg::frpc_cmd_t cmd,
  input wire frpc_pkg::frpc_status_t status,
  input wire logic [`FRPC_CFG2_WIDTH-1:0] second_config_register,
  input wire logic octal_data_lines_oe,
  input wire logic core_hold,
  input wire logic low_power,
  input wire logic cmd_accept,
  input wire logic abort_op,
  input wire logic fastboot_start,
  input wire logic soft_reset_done
);
  import frpc_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_HOLD_FLOAT: assert property (low_power |-> !octal_data_lines_oe)
    else $error("data lines driven in hold");
  AST_PIN_HOLD: assert property (!reset_pin_n [*8] |=> core_hold && low_power)
    else $error("pin reset not taken");
  AST_NO_CMD: assert property (low_power |-> !cmd_accept)
    else $error("commands taken in hold");
  AST_ARM_EXEC: assert property (cmd.valid && cmd.reset_exec_cmd && cmd_accept
    && $past(cmd.valid && cmd.reset_arm_cmd) |=> soft_reset_done)
    else $error("armed reset not executed");
  AST_DONE_CAUSE: assert property (soft_reset_done |-> $past(cmd.reset_exec_cmd))
    else $error("soft reset without execute");
  // standby also returns when an operation ends, which clears only the busy flag; only leaving hold counts
  AST_FLAGS: assert property (soft_reset_done ||
    ($rose(status.standby) && $past(low_power)) |->
    !status.write_latch_flag && !status.write_busy_flag)
    else $error("flags not cleared by reset");
  AST_CFG2: assert property (soft_reset_done ||
    ($rose(status.standby) && $past(low_power)) |->
    second_config_register == `FRPC_CFG2_DEFAULT)
    else $error("cfg2 not at default after reset");
  AST_BOOT: assert property (fastboot_start |-> !chip_select_n && $past(chip_select_n, 6))
    else $error("fastboot without select");
  AST_ABORT: assert property (abort_op |-> core_hold && !status.write_busy_flag)
    else $error("abort outside reset");
  // the core may start work in the first free cycle, so look at the state on leaving hold
  AST_POWER: assert property ($rose(cmd_accept) |-> $past(status.standby) &&
    !$past(status.write_latch_flag))
    else $error("bad state at power-up");
endmodule
bind frpc_top frpc_top_props i_props (.core_clk, .rst_n, .reset_pin_n, .chip_select_n, .cmd,
  .status, .second_config_register, .octal_data_lines_oe, .core_hold, .low_power,
  .cmd_accept, .abort_op, .fastboot_start, .soft_reset_done);

// [frpc_host_model.sv]
// Purpose: host controller driving reset and chip select pins
// Assumes: one 200 ns link period stands in for one microsecond
// Notes: millisecond waits are cut a hundredfold to keep the run short
`timescale 1ns/1ps
module frpc_host_model (
  input wire logic core_clk,
  output logic reset_pin_n,
  output logic chip_select_n
);
  localparam int UNIT_NS = 200;
  // standby, read, program, small sector, large block, chip, status write
  int recov [7] = '{35, 40, 310, 120, 250, 1000, 400};
  int last_op = 0;
  initial begin
    reset_pin_n = 1'b1;
    chip_select_n = 1'b1;
  end
  task hw_reset(input int op);
    @(negedge core_clk);
    last_op = op;
    reset_pin_n = 1'b0;
    #(10 * UNIT_NS);
    reset_pin_n = 1'b1;
    #(recov[last_op] * UNIT_NS);
  endtask
  task soft_recover(input int op);
    last_op = op;
    #(recov[last_op] * UNIT_NS);
  endtask
  task select(input int n);
    @(negedge core_clk);
    chip_select_n = 1'b0;
    #(n * UNIT_NS);
    chip_select_n = 1'b1;
    #(UNIT_NS);
  endtask
endmodule

// [frpc_top_tb.sv]
// Purpose: self-checking bench for frpc_top
// Assumes: host model drives the pins, bench drives core side at falling edges
// Notes: pulses are collected over a short window since their cycle is a design choice
`timescale 1ns/1ps
`include "frpc_defines.svh"
module frpc_top_tb;
  import frpc_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  frpc_cmd_t cmd = '0;
  frpc_core_t core_ev = '0;
  logic data_drive_req = 1'b0;
  logic cfg2_wr_en = 1'b0;
  logic [7:0] cfg2_wr_data = 8'h00;
  wire logic reset_pin_n;
  wire logic chip_select_n;
  frpc_status_t status;
  logic [`FRPC_CFG2_WIDTH-1:0] cfg2;
  logic oe, hold, lp, acc, abrt, fb, srd;
  int err_total = 0;
  int n_checks = 0;
  always #12.5 core_clk = ~core_clk;
  frpc_host_model i_host (.core_clk(core_clk), .reset_pin_n(reset_pin_n),
    .chip_select_n(chip_select_n));
  frpc_top i_dut (.core_clk(core_clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
    .chip_select_n(chip_select_n), .cmd(cmd), .core_ev(core_ev),
    .data_drive_req(data_drive_req), .cfg2_wr_en(cfg2_wr_en), .cfg2_wr_data(cfg2_wr_data),
    .status(status), .second_config_register(cfg2), .octal_data_lines_oe(oe),
    .core_hold(hold), .low_power(lp), .cmd_accept(acc), .abort_op(abrt),
    .fastboot_start(fb), .soft_reset_done(srd));
  task conclude;
    if (err_total == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task issue(input frpc_cmd_t c);
    cmd = c;
    cyc(1);
  endtask
  task t_power;
    int i;
    for (i = 0; i < 20 && acc !== 1'b1; i++) cyc(1);
    if (acc !== 1'b1) begin
      err_total++;
      conclude();
    end
    chk("status", 8'h04, {5'h00, status});
    chk("cfg2", `FRPC_CFG2_DEFAULT, cfg2);
  endtask
  // a cancelling command sits between arm and execute, else an idle cycle does
  task t_soft(input logic cancel, input logic busy, input logic [7:0] exp);
    logic done, ab;
    done = 1'b0;
    ab = 1'b0;
    if (busy) begin
      core_ev = 5'b1_0101;
      cyc(1);
      core_ev = '0;
    end
    issue(3'b110);
    if (cancel) issue(3'b100);
    else issue(3'b000);
    issue(3'b101);
    cmd = '0;
    // the pulses stand only until the next edge, so look before stepping
    repeat (4) begin
      done |= srd;
      ab |= abrt;
      cyc(1);
    end
    chk("soft_reset_done", {7'h00, exp[0]}, {7'h00, done});
    chk("abort_op", {7'h00, exp[1]}, {7'h00, ab});
    if (exp[0]) chk("status", 8'h04, {5'h00, status});
    if (exp[0]) i_host.soft_recover(busy ? 2 : 0);
  endtask
  task t_pin;
    core_ev = 5'b1_0000;
    cfg2_wr_en = 1'b1;
    cfg2_wr_data = 8'ha5;
    data_drive_req = 1'b1;
    cyc(1);
    core_ev = '0;
    cfg2_wr_en = 1'b0;
    chk("cfg2 write", 8'ha5, cfg2);
    chk("oe driving", 8'h01, {7'h00, oe});
    fork
      i_host.hw_reset(2);
      begin
        cyc(30);
        chk("oe in hold", 8'h00, {7'h00, oe});
        chk("low_power", 8'h01, {7'h00, lp});
        chk("cmd_accept", 8'h00, {7'h00, acc});
        chk("core_hold", 8'h01, {7'h00, hold});
        t_soft(1'b0, 1'b0, 8'h00);
      end
    join
    data_drive_req = 1'b0;
    chk("status", 8'h04, {5'h00, status});
    chk("cfg2", `FRPC_CFG2_DEFAULT, cfg2);
  endtask
  task t_boot(input logic [7:0] exp);
    logic seen;
    seen = 1'b0;
    fork
      i_host.select(2);
      repeat (12) begin
        cyc(1);
        seen |= fb;
      end
    join
    chk("fastboot_start", exp, {7'h00, seen});
  endtask
  initial begin
    #200000;
    err_total++;
    conclude();
  end
  initial begin
    cyc(3);
    rst_n = 1'b1;
    t_power();
    t_soft(1'b0, 1'b1, 8'h03);
    t_soft(1'b1, 1'b0, 8'h00);
    t_pin();
    t_boot(8'h01);
    t_boot(8'h00);
    conclude();
  end
endmodule
